// ### shared/nse_pkg.sv
`default_nettype none
package nse_pkg;

  // ****************************************************************
  // Store variants and fault codes
  // ****************************************************************
  typedef enum logic [2:0] {
    NSE_OP_BYTE_U = 3'b000,
    NSE_OP_BYTE_S = 3'b001,
    NSE_OP_HALF_U = 3'b010,
    NSE_OP_HALF_S = 3'b011,
    NSE_OP_DWORD  = 3'b100
  } nse_op_t;

  typedef enum logic [2:0] {
    NSE_FLT_NONE     = 3'b000,
    NSE_FLT_MISMATCH = 3'b001,
    NSE_FLT_INVALID  = 3'b010,
    NSE_FLT_OVERFLOW = 3'b011,
    NSE_FLT_UNALIGN  = 3'b100
  } nse_fault_t;

  // ****************************************************************
  // Widths, byte enables, address step
  // ****************************************************************
  localparam int          NSE_BYTE_BITS = 8;
  localparam int          NSE_HALF_BITS = 16;
  localparam logic [3:0]  NSE_BE_BYTE   = 4'h1;
  localparam logic [3:0]  NSE_BE_HALF   = 4'h3;
  localparam logic [3:0]  NSE_BE_WORD   = 4'hf;
  localparam logic [31:0] NSE_WORD_STEP = 32'h4;
  localparam logic [2:0]  NSE_DW_ALIGN  = 3'h7;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    nse_op_t     op;
    logic [31:0] src;
    logic [31:0] src_next;
    logic [4:0]  reg_num;
    logic [31:0] addr;
    logic        overflow_mask;
    logic        unaligned_en;
    logic        illegal_write;
  } nse_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  be;
  } nse_mem_t;

  // True when the bits above the low width are all zeros or all ones.
  // The top stored bit is left out on purpose, so 0x000000ff passes a byte
  // range check; software must not count on a stricter test.
  function automatic logic nse_fits_signed(input logic [31:0] v, input int w);
    logic [31:0] hi;
    hi = v >> w;
    return (hi == 32'h0) || (hi == (32'hffffffff >> w));
  endfunction : nse_fits_signed

endpackage : nse_pkg
`default_nettype wire

// ### rtl/nse_check.sv
`default_nettype none
module nse_check
  import nse_pkg::*;
(
  input  wire nse_req_t   req,
  output nse_fault_t      early_fault,
  output nse_fault_t      late_fault,
  output logic            ovf_set
);

  logic sgn;
  logic fits;
  logic misal;

  // ****************************************************************
  // Fault classification in priority order
  // ****************************************************************
  always_comb begin
    sgn   = (req.op == NSE_OP_BYTE_S) || (req.op == NSE_OP_HALF_S);
    fits  = (req.op == NSE_OP_BYTE_S) ? nse_fits_signed(req.src, NSE_BYTE_BITS)
                                      : nse_fits_signed(req.src, NSE_HALF_BITS);
    // Bytes can never be misaligned
    case (req.op)
      NSE_OP_HALF_U, NSE_OP_HALF_S: misal = req.addr[0];
      NSE_OP_DWORD:                 misal = |(req.addr[2:0] & NSE_DW_ALIGN);
      default:                      misal = 1'b0;
    endcase
    early_fault = NSE_FLT_NONE;
    late_fault  = NSE_FLT_NONE;
    ovf_set     = 1'b0;
    if (req.illegal_write) begin
      early_fault = NSE_FLT_MISMATCH; // R01 R08
    end else if ((req.op == NSE_OP_DWORD) && req.reg_num[0]) begin
      early_fault = NSE_FLT_INVALID; // R06 R08
    end else begin
      if (sgn && !fits) begin
        if (req.overflow_mask) begin
          ovf_set = 1'b1; // R03 R04
        end else begin
          late_fault = NSE_FLT_OVERFLOW; // R03 R04
        end
      end
      // Alignment is looked at only when no range fault stands
      if ((late_fault == NSE_FLT_NONE) && req.unaligned_en && misal) begin
        late_fault = NSE_FLT_UNALIGN; // R05 R07 R08
      end
    end
  end

endmodule : nse_check
`default_nettype wire

// ### rtl/nse_store.sv
// What this block does
// R01: Illegal write to protected RAM or mapped space: mismatch fault, no write.
// R02: Byte stores always write the low eight source bits, signed or not.
// R03: Signed byte out of range: set sticky flag if masked, else overflow fault.
// R04: Signed halfword out of range: still write low 16 bits, then flag or fault.
// R05: Misaligned halfword with faulting enabled: write first, then unaligned fault.
// R06: Doubleword with odd source register: invalid-operand fault, no write.
// R07: Doubleword writes source at address, next register at plus four, then aligns.
// R08: Priority: illegal write, then operand and range, then alignment; one fault.
`default_nettype none
module nse_store
  import nse_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       req_valid,
  input  wire nse_req_t   req,
  output logic            req_ready,
  output nse_mem_t        mem_wr,
  output logic            done,
  output nse_fault_t      fault,
  input  wire logic       overflow_clear,
  output logic            overflow_sticky_flag
);

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  typedef enum logic [1:0] {
    NSE_S_IDLE   = 2'b00,
    NSE_S_SECOND = 2'b01,
    NSE_S_FINISH = 2'b10
  } nse_state_t;

  nse_state_t  state_q,    state_d;
  logic        ready_q,    ready_d;
  nse_mem_t    mem_q,      mem_d;
  logic        done_q,     done_d;
  nse_fault_t  fault_q,    fault_d;
  nse_fault_t  pend_q,     pend_d;
  logic        pend_ovf_q, pend_ovf_d;
  logic        flag_q,     flag_d;
  logic [31:0] next_q,     next_d;

  nse_fault_t  early_fault;
  nse_fault_t  late_fault;
  logic        ovf_set;
  logic        accept;

  nse_check u_check (
    .req         (req),
    .early_fault (early_fault),
    .late_fault  (late_fault),
    .ovf_set     (ovf_set)
  );

  assign accept = req_valid && ready_q;

  // ****************************************************************
  // Next state: write phases, then one finishing pulse
  // ****************************************************************
  always_comb begin
    state_d    = state_q;
    ready_d    = ready_q;
    mem_d      = mem_q;
    mem_d.valid = 1'b0;
    done_d     = 1'b0;
    fault_d    = NSE_FLT_NONE;
    pend_d     = pend_q;
    pend_ovf_d = 1'b0;
    next_d     = next_q;
    flag_d     = flag_q;
    case (state_q)
      NSE_S_IDLE: begin
        if (accept) begin
          if (early_fault != NSE_FLT_NONE) begin
            // Rejected stores finish at once and keep the port open
            done_d  = 1'b1; // R01 R06
            fault_d = early_fault; // R08
          end else begin
            mem_d.valid = 1'b1;
            mem_d.addr  = req.addr;
            pend_d      = late_fault;
            pend_ovf_d  = ovf_set;
            next_d      = req.src_next;
            case (req.op)
              NSE_OP_BYTE_U, NSE_OP_BYTE_S: begin
                mem_d.data = {24'h0, req.src[7:0]}; // R02
                mem_d.be   = NSE_BE_BYTE;
              end
              NSE_OP_HALF_U, NSE_OP_HALF_S: begin
                mem_d.data = {16'h0, req.src[15:0]}; // R04 R05
                mem_d.be   = NSE_BE_HALF;
              end
              default: begin
                mem_d.data = req.src; // R07
                mem_d.be   = NSE_BE_WORD;
              end
            endcase
            state_d = (req.op == NSE_OP_DWORD) ? NSE_S_SECOND : NSE_S_FINISH;
            ready_d = 1'b0;
          end
        end
      end
      NSE_S_SECOND: begin
        // Second word goes out before any fault is reported
        mem_d.valid = 1'b1;
        mem_d.addr  = mem_q.addr + NSE_WORD_STEP; // R07
        mem_d.data  = next_q;
        mem_d.be    = NSE_BE_WORD;
        pend_ovf_d  = pend_ovf_q;
        state_d     = NSE_S_FINISH;
      end
      NSE_S_FINISH: begin
        done_d  = 1'b1;
        fault_d = pend_q; // R05 R07
        state_d = NSE_S_IDLE;
        ready_d = 1'b1;
      end
      default: begin
        state_d = NSE_S_IDLE;
        ready_d = 1'b1;
      end
    endcase
    // Sticky flag: a set in the clearing cycle wins
    if (state_q == NSE_S_FINISH && pend_ovf_q) begin
      flag_d = 1'b1; // R03 R04
    end else if (overflow_clear) begin
      flag_d = 1'b0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q    <= NSE_S_IDLE;
      ready_q    <= 1'b1;
      mem_q      <= '0;
      done_q     <= 1'b0;
      fault_q    <= NSE_FLT_NONE;
      pend_q     <= NSE_FLT_NONE;
      pend_ovf_q <= 1'b0;
      flag_q     <= 1'b0;
      next_q     <= 32'h0;
    end else begin
      state_q    <= state_d;
      ready_q    <= ready_d;
      mem_q      <= mem_d;
      done_q     <= done_d;
      fault_q    <= fault_d;
      pend_q     <= pend_d;
      pend_ovf_q <= pend_ovf_d;
      flag_q     <= flag_d;
      next_q     <= next_d;
    end
  end

  // Outputs straight from flops
  assign req_ready            = ready_q;
  assign mem_wr               = mem_q;
  assign done                 = done_q;
  assign fault                = fault_q;
  assign overflow_sticky_flag = flag_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [7:0] src_byte;
  logic       fits8;
  logic       fits16;
  logic       clean;

  assign src_byte = req.src[7:0];
  assign fits8    = nse_fits_signed(req.src, NSE_BYTE_BITS);
  assign fits16   = nse_fits_signed(req.src, NSE_HALF_BITS);
  assign clean    = accept && !req.illegal_write;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  mismatch_no_write_a: assert property ( // R01
    accept && req.illegal_write |=> !mem_q.valid && done_q && fault_q == NSE_FLT_MISMATCH
  ) else $error("illegal write was not refused");

  byte_low_a: assert property ( // R02
    clean && (req.op == NSE_OP_BYTE_U || req.op == NSE_OP_BYTE_S)
    |=> mem_q.valid && mem_q.be == NSE_BE_BYTE && mem_q.data[7:0] == $past(src_byte)
  ) else $error("byte store data wrong");

  sbyte_fault_a: assert property ( // R03
    clean && req.op == NSE_OP_BYTE_S && !fits8 && !req.overflow_mask
    |=> mem_q.valid ##1 done_q && fault_q == NSE_FLT_OVERFLOW
  ) else $error("signed byte overflow fault missing");

  sbyte_flag_a: assert property ( // R03
    clean && req.op == NSE_OP_BYTE_S && !fits8 && req.overflow_mask
    |-> ##2 (done_q && fault_q == NSE_FLT_NONE && overflow_sticky_flag)
  ) else $error("masked overflow did not set flag");

  half_flag_a: assert property ( // R04
    clean && req.op == NSE_OP_HALF_S && !fits16 && req.overflow_mask
    |-> ##2 (done_q && overflow_sticky_flag)
  ) else $error("masked halfword overflow did not set flag");

  flag_clear_a: assert property ( // R03
    overflow_clear && !(state_q == NSE_S_FINISH && pend_ovf_q) |=> !overflow_sticky_flag
  ) else $error("sticky flag not cleared");

  half_range_a: assert property ( // R04
    clean && req.op == NSE_OP_HALF_S && !fits16
    |=> mem_q.valid && mem_q.be == NSE_BE_HALF
  ) else $error("out of range halfword not written");

  half_unal_a: assert property ( // R05
    clean && req.op == NSE_OP_HALF_U && req.addr[0] && req.unaligned_en
    |=> mem_q.valid ##1 (done_q && fault_q == NSE_FLT_UNALIGN)
  ) else $error("unaligned halfword sequence wrong");

  dword_odd_a: assert property ( // R06
    clean && req.op == NSE_OP_DWORD && req.reg_num[0]
    |=> !mem_q.valid && done_q && fault_q == NSE_FLT_INVALID
  ) else $error("odd register doubleword not refused");

  dword_pair_a: assert property ( // R07
    clean && req.op == NSE_OP_DWORD && !req.reg_num[0]
    |=> mem_q.valid ##1 (mem_q.valid && mem_q.addr == $past(mem_q.addr) + NSE_WORD_STEP)
        ##1 (done_q && !mem_q.valid)
  ) else $error("doubleword pair sequence wrong");

  fault_prio_a: assert property ( // R08
    accept && req.illegal_write && req.op == NSE_OP_DWORD && req.reg_num[0]
    |=> fault_q == NSE_FLT_MISMATCH
  ) else $error("fault priority wrong");

endmodule : nse_store
`default_nettype wire

// ### sim/nse_mem_model.sv
`default_nettype none
module nse_mem_model
  import nse_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       clr,
  input  wire nse_mem_t   mem_wr,
  input  wire logic       done,
  input  wire nse_fault_t fault,
  output logic [1:0]      wr_cnt,
  output nse_mem_t        wr0,
  output nse_mem_t        wr1,
  output logic            got_done,
  output nse_fault_t      got_fault
);
  timeunit 1ns;
  timeprecision 1ns;

  // Write path takes every write at once; logs the first two in order
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      wr_cnt   <= 2'h0;
      got_done <= 1'h0;
    end else begin
      if (mem_wr.valid) begin
        if (wr_cnt == 2'h0) begin
          wr0 <= mem_wr;
        end else begin
          wr1 <= mem_wr;
        end
        wr_cnt <= wr_cnt + 2'h1;
      end
      // Fault handler keeps the code seen with the finish pulse
      if (done) begin
        got_done  <= 1'h1;
        got_fault <= fault;
      end
    end
  end
endmodule : nse_mem_model
`default_nettype wire

// ### sim/nse_store_tb.sv
`default_nettype none
module nse_store_tb;
  import nse_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk, resetn, req_valid, req_ready, done, overflow_clear, flag, clr, got_done;
  logic [1:0] wr_cnt;
  nse_req_t   req;
  nse_mem_t   mem_wr, wr0, wr1;
  nse_fault_t fault, got_fault;
  int         err_count, check_count;

  // ********************
  // Clock, parts
  // ********************
  initial begin
    ref_clk = 1'h0;
    forever #10 ref_clk = ~ref_clk;
  end
  nse_store uut (.ref_clk(ref_clk), .resetn(resetn), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .mem_wr(mem_wr), .done(done), .fault(fault),
    .overflow_clear(overflow_clear), .overflow_sticky_flag(flag));
  nse_mem_model far (.ref_clk(ref_clk), .clr(clr), .mem_wr(mem_wr), .done(done),
    .fault(fault), .wr_cnt(wr_cnt), .wr0(wr0), .wr1(wr1), .got_done(got_done),
    .got_fault(got_fault));

  // ********************
  // Shared tasks
  // ********************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One store: ctl is {overflow mask, unaligned enable, illegal write}
  task automatic go(input nse_op_t op, input logic [31:0] s, input logic [31:0] s2,
    input logic [4:0] rn, input logic [31:0] a, input logic [2:0] ctl, input int n,
    input nse_fault_t ef);
    logic [31:0] m;
    logic [3:0]  be;
    int          k;
    m  = (op == NSE_OP_DWORD) ? 32'hffffffff : (op[2:1] == 2'h0 ? 32'hff : 32'hffff);
    be = (op == NSE_OP_DWORD) ? NSE_BE_WORD : (op[2:1] == 2'h0 ? NSE_BE_BYTE : NSE_BE_HALF);
    @(posedge ref_clk);
    req       <= '{op, s, s2, rn, a, ctl[2], ctl[1], ctl[0]};
    req_valid <= 1'h1;
    clr       <= 1'h1;
    @(posedge ref_clk);
    req_valid <= 1'h0;
    clr       <= 1'h0;
    k = 0;
    #1;
    // Only refused stores keep the port open after the take
    chk("ready", {31'h0, req_ready}, {31'h0, ef == NSE_FLT_MISMATCH || ef == NSE_FLT_INVALID});
    // Bounded wait; finish comes within three cycles of the take
    do begin
      @(posedge ref_clk);
      #1;
      k++;
    end while (got_done !== 1'h1 && k < 8);
    chk("done", {31'h0, got_done}, 32'h1);
    chk("fault", {29'h0, got_fault}, {29'h0, ef});
    chk("writes", {30'h0, wr_cnt}, n);
    chk("ready_end", {31'h0, req_ready}, 32'h1);
    if (n > 0) begin
      chk("addr", wr0.addr, a);
      chk("data", wr0.data & m, s & m);
      chk("be", {28'h0, wr0.be}, {28'h0, be});
    end
    if (n > 1) begin
      chk("addr2", wr1.addr, a + NSE_WORD_STEP);
      chk("data2", wr1.data, s2);
      chk("be2", {28'h0, wr1.be}, 32'hf);
    end
  endtask : go

  task automatic fl(input logic e);
    chk("flag", {31'h0, flag}, {31'h0, e});
  endtask : fl

  // ********************
  // Scenarios
  // ********************
  task automatic t_byte;
    go(NSE_OP_BYTE_U, 32'h12345678, 32'h0, 5'h0, 32'h100, 3'h0, 1, NSE_FLT_NONE);
    go(NSE_OP_BYTE_S, 32'h000000ff, 32'h0, 5'h0, 32'h104, 3'h0, 1, NSE_FLT_NONE);
    go(NSE_OP_BYTE_S, 32'hffffff80, 32'h0, 5'h0, 32'h101, 3'h0, 1, NSE_FLT_NONE);
    fl(1'h0);
    go(NSE_OP_BYTE_S, 32'h00001280, 32'h0, 5'h0, 32'h102, 3'h4, 1, NSE_FLT_NONE);
    fl(1'h1);
    @(posedge ref_clk);
    overflow_clear <= 1'h1;
    @(posedge ref_clk);
    overflow_clear <= 1'h0;
    #1;
    fl(1'h0);
    go(NSE_OP_BYTE_S, 32'h00000100, 32'h0, 5'h0, 32'h103, 3'h0, 1, NSE_FLT_OVERFLOW);
    fl(1'h0);
    $display("test byte done");
  endtask : t_byte

  task automatic t_half;
    go(NSE_OP_HALF_S, 32'h00018001, 32'h0, 5'h0, 32'h200, 3'h0, 1, NSE_FLT_OVERFLOW);
    go(NSE_OP_HALF_S, 32'hffff8001, 32'h0, 5'h0, 32'h200, 3'h0, 1, NSE_FLT_NONE);
    go(NSE_OP_HALF_S, 32'h0000ffff, 32'h0, 5'h0, 32'h204, 3'h0, 1, NSE_FLT_NONE);
    go(NSE_OP_HALF_U, 32'habcd1234, 32'h0, 5'h0, 32'h201, 3'h2, 1, NSE_FLT_UNALIGN);
    go(NSE_OP_HALF_S, 32'h00001234, 32'h0, 5'h0, 32'h203, 3'h2, 1, NSE_FLT_UNALIGN);
    go(NSE_OP_HALF_U, 32'habcd1234, 32'h0, 5'h0, 32'h201, 3'h0, 1, NSE_FLT_NONE);
    $display("test half done");
  endtask : t_half

  task automatic t_dword;
    go(NSE_OP_DWORD, 32'h11223344, 32'h55667788, 5'h4, 32'h300, 3'h2, 2, NSE_FLT_NONE);
    go(NSE_OP_DWORD, 32'h0badf00d, 32'hcafe0001, 5'h4, 32'h304, 3'h2, 2, NSE_FLT_UNALIGN);
    go(NSE_OP_DWORD, 32'h0badf00d, 32'hcafe0001, 5'h6, 32'h302, 3'h0, 2, NSE_FLT_NONE);
    go(NSE_OP_DWORD, 32'h0badf00d, 32'hcafe0001, 5'h5, 32'h300, 3'h0, 0, NSE_FLT_INVALID);
    $display("test dword done");
  endtask : t_dword

  task automatic t_prio;
    for (int i = 0; i < 5; i++) begin
      go(nse_op_t'(i), 32'h00018001, 32'h0, 5'h5, 32'h403, 3'h3, 0, NSE_FLT_MISMATCH);
    end
    go(NSE_OP_DWORD, 32'h1, 32'h2, 5'h5, 32'h403, 3'h2, 0, NSE_FLT_INVALID);
    go(NSE_OP_HALF_S, 32'h00018001, 32'h0, 5'h0, 32'h401, 3'h2, 1, NSE_FLT_OVERFLOW);
    go(NSE_OP_HALF_S, 32'h00018001, 32'h0, 5'h0, 32'h401, 3'h6, 1, NSE_FLT_UNALIGN);
    fl(1'h1);
    $display("test priority done");
  endtask : t_prio

  // ********************
  // Run and verdict
  // ********************
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // Whole run is under two microseconds; a hang stops well past that
  initial begin
    #20us;
    err_count++;
    summarize();
  end

  initial begin
    resetn         = 1'h0;
    req_valid      = 1'h0;
    req            = '0;
    overflow_clear = 1'h0;
    clr            = 1'h1;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'h1;
    t_byte();
    t_half();
    t_dword();
    t_prio();
    summarize();
  end
endmodule : nse_store_tb
`default_nettype wire
